// ==== hdl/sbrg_defines.svh ====
// Constants of the serial bit-rate generator: register offsets, field positions, reset values.
// Assumes an APB slave with 32-bit data, one aligned word per register.
`ifndef SBRG_DEFINES_SVH
`define SBRG_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SBRG_OFS_RX_CTL 12'h000
`define SBRG_OFS_DIVISOR 12'h004
`define SBRG_OFS_TX_CTL 12'h008
`define SBRG_OFS_STATUS 12'h00C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SBRG_BIT_PORT_EN 7
`define SBRG_BIT_SYNC_MODE 4
`define SBRG_BIT_HIGH_SPEED 2

// ----------------------------------------------------------------
// Reset values and prescale counts
// ----------------------------------------------------------------
`define SBRG_RST_RX_CTL 8'h00
`define SBRG_RST_DIVISOR 8'h00
`define SBRG_RST_TX_CTL 8'h02
`define SBRG_TX_CTL_WMASK 8'hF5
`define SBRG_PRE_ASYNC_LO 6'h3F
`define SBRG_PRE_ASYNC_HI 6'h0F
`define SBRG_PRE_SYNC 6'h03

`endif

// ==== hdl/sbrg_pkg.sv ====
// Types shared by the serial bit-rate generator.
// Assumes nothing beyond a SystemVerilog compiler.
package sbrg_pkg;

	// Rate selection derived from mode and speed bits
	typedef enum logic [1:0]
	{
		SBRG_ASYNC_LO = 2'b00,
		SBRG_ASYNC_HI = 2'b01,
		SBRG_SYNC = 2'b10
	} sbrg_rate_t;

endpackage

// ==== hdl/sbrg_top.sv ====
// Serial bit-rate generator with APB register access.
// Assumes one 40 MHz clock pclk; transmitter and receiver consume the ticks elsewhere.
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "sbrg_defines.svh"

module sbrg_top
(
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Rate outputs
	output logic timer_tick,
	output logic bit_rate_tick,
	output logic port_reset
);

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic acc;
	logic wr;
	logic hit_rc;
	logic hit_div;
	logic hit_tx;
	logic hit_st;
	assign acc = psel & penable & clk_en;
	assign wr = acc & pwrite;
	assign hit_rc = (paddr == `SBRG_OFS_RX_CTL);
	assign hit_div = (paddr == `SBRG_OFS_DIVISOR);
	assign hit_tx = (paddr == `SBRG_OFS_TX_CTL);
	assign hit_st = (paddr == `SBRG_OFS_STATUS);
	// Zero wait states; a stalled clock enable stretches the access
	assign pready = clk_en;
	assign pslverr = acc & ~(hit_rc | hit_div | hit_tx | hit_st);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0] rx_ctl_q;
	logic [7:0] divisor_q;
	logic [7:0] tx_ctl_q;
	logic div_wr;
	assign div_wr = wr & hit_div;

	// Receive control; only the enable bit matters here, others stored
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rx_ctl_q <= `SBRG_RST_RX_CTL;
		else if (wr && hit_rc)
			rx_ctl_q <= pwdata[7:0];
	end

	// Divisor value
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			divisor_q <= `SBRG_RST_DIVISOR;
		else if (div_wr)
			divisor_q <= pwdata[7:0];
	end

	// Transmit control; bit 1 is read-only shifter-empty, bit 3 unimplemented
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tx_ctl_q <= `SBRG_RST_TX_CTL;
		else if (wr && hit_tx)
			tx_ctl_q <= (pwdata[7:0] & `SBRG_TX_CTL_WMASK) | (tx_ctl_q & ~`SBRG_TX_CTL_WMASK);
	end

	// ----------------------------------------------------------------
	// Mode selection
	// ----------------------------------------------------------------
	logic port_en;
	sbrg_pkg::sbrg_rate_t rate_sel;
	logic [5:0] pre_top;
	assign port_en = rx_ctl_q[`SBRG_BIT_PORT_EN];
	assign port_reset = ~port_en;

	// Speed bit only consulted when asynchronous
	always_comb
	begin
		if (tx_ctl_q[`SBRG_BIT_SYNC_MODE])
			rate_sel = sbrg_pkg::SBRG_SYNC;
		else if (tx_ctl_q[`SBRG_BIT_HIGH_SPEED])
			rate_sel = sbrg_pkg::SBRG_ASYNC_HI;
		else
			rate_sel = sbrg_pkg::SBRG_ASYNC_LO;
	end

	// Prescale terminal value per mode
	always_comb
	begin
		unique case (rate_sel)
			sbrg_pkg::SBRG_ASYNC_LO: pre_top = `SBRG_PRE_ASYNC_LO;
			sbrg_pkg::SBRG_ASYNC_HI: pre_top = `SBRG_PRE_ASYNC_HI;
			sbrg_pkg::SBRG_SYNC: pre_top = `SBRG_PRE_SYNC;
			default: pre_top = `SBRG_PRE_ASYNC_LO;
		endcase
	end

	// ----------------------------------------------------------------
	// Bit-rate timer and prescaler
	// ----------------------------------------------------------------
	logic [7:0] timer_q;
	logic [5:0] pre_q;
	logic timer_tc;
	assign timer_tc = (timer_q == 8'h00);

	// Down counter reloading from divisor: n+1 cycles per tick
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			timer_q <= 8'h00;
		else if (clk_en)
		begin
			if (!port_en || div_wr)
				timer_q <= 8'h00;
			else if (timer_tc)
				timer_q <= divisor_q;
			else
				timer_q <= timer_q - 8'h01;
		end
	end

	// Timer tick registered so it is a clean one-cycle pulse; with a zero divisor it stays high
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			timer_tick <= 1'b0;
		else if (clk_en)
			timer_tick <= port_en & ~div_wr & timer_tc;
	end

	// Prescaler counts timer ticks; cleared too so a new divisor starts clean
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pre_q <= 6'h00;
		else if (clk_en)
		begin
			if (!port_en || div_wr)
				pre_q <= 6'h00;
			else if (timer_tick)
				pre_q <= (pre_q >= pre_top) ? 6'h00 : pre_q + 6'h01;
		end
	end

	// Bit-rate tick: one per factor*(n+1) cycles
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			bit_rate_tick <= 1'b0;
		else if (clk_en)
			bit_rate_tick <= port_en & ~div_wr & timer_tick & (pre_q >= pre_top);
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (psel && !penable && !pwrite && clk_en)
		begin
			if (hit_rc)
				prdata <= {24'h000000, rx_ctl_q};
			else if (hit_div)
				prdata <= {24'h000000, divisor_q};
			else if (hit_tx)
				prdata <= {24'h000000, tx_ctl_q};
			else if (hit_st)
				prdata <= {18'h00000, pre_q, timer_q};
			else
				prdata <= 32'h00000000;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_div_write;
		div_wr;
	endsequence

	chk_write_clears_timer: assert property (@(posedge pclk) disable iff (!presetn)
		s_div_write |=> (timer_q == 8'h00 && pre_q == 6'h00))
		else $error("timer not cleared by divisor write");
	chk_disable_holds_timer: assert property (@(posedge pclk) disable iff (!presetn)
		(!port_en && clk_en) |=> (timer_q == 8'h00 && !bit_rate_tick))
		else $error("timer runs while port disabled");
	chk_reload_divisor: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && port_en && !div_wr && timer_tc) |=> (timer_q == $past(divisor_q)))
		else $error("timer did not reload divisor");
	chk_tick_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
		(timer_tick && clk_en && divisor_q != 8'h00) |=> !timer_tick)
		else $error("timer tick longer than one cycle");
	chk_sync_ignores_speed: assert property (@(posedge pclk) disable iff (!presetn)
		tx_ctl_q[`SBRG_BIT_SYNC_MODE] |-> (pre_top == `SBRG_PRE_SYNC))
		else $error("sync mode prescale wrong");
	chk_async_high: assert property (@(posedge pclk) disable iff (!presetn)
		(!tx_ctl_q[`SBRG_BIT_SYNC_MODE] && tx_ctl_q[`SBRG_BIT_HIGH_SPEED]) |-> (pre_top == `SBRG_PRE_ASYNC_HI))
		else $error("high speed prescale wrong");
	chk_async_low: assert property (@(posedge pclk) disable iff (!presetn)
		(!tx_ctl_q[`SBRG_BIT_SYNC_MODE] && !tx_ctl_q[`SBRG_BIT_HIGH_SPEED]) |-> (rate_sel == sbrg_pkg::SBRG_ASYNC_LO))
		else $error("low speed mode wrong");
	// A tick held through a stalled enable was launched earlier, so only judge freshly launched ticks
	chk_rate_tick_cause: assert property (@(posedge pclk) disable iff (!presetn)
		(bit_rate_tick && $past(clk_en)) |-> $past(timer_tick) && $past(pre_q >= pre_top))
		else $error("bit rate tick without terminal prescale");
	chk_timer_width: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && port_en && !div_wr && !timer_tc) |=> (timer_q == $past(timer_q) - 8'h01))
		else $error("timer did not count down");

endmodule

// ==== test/sbrg_tb.sv ====
// Self-checking bench for the serial bit-rate generator: APB register access and tick periods.
// Assumes the design files under hdl/ are compiled first and the include path reaches them.
`timescale 1ns/1ps
`include "sbrg_defines.svh"

module serial_baud_rate_generator_tb_top;

	// Clock, reset, enable
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic clk_en = 1'b1;
	// APB master side
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	// Rate outputs
	logic timer_tick;
	logic bit_rate_tick;
	logic port_reset;
	int num_errors = 0;
	int cmp_count = 0;
	logic [31:0] rd;
	logic er;
	int per;
	// Modes: transmit control value, divisor, expected prescale factor
	logic [7:0] mode_tx [4] = '{8'h00, 8'h04, 8'h10, 8'h14};
	logic [7:0] mode_n [4] = '{8'h03, 8'h03, 8'h05, 8'h05};
	int mode_f [4] = '{64, 16, 4, 4};

	sbrg_top i_sbrg_top
	(
		.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .timer_tick(timer_tick), .bit_rate_tick(bit_rate_tick), .port_reset(port_reset)
	);

	// ----------------------------------------------------------------
	// Clock at 40 MHz
	// ----------------------------------------------------------------
	initial
	begin
		forever #12.5 pclk = ~pclk;
	end

	task automatic print_verdict();
		if (num_errors == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer; holds the request until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			num_errors++;
			print_verdict();
		end
		else
		begin
			r = prdata;
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	// Cycles until the chosen tick is seen high; a bound guards against a dead output
	task automatic wait_tick(input bit which, output int c);
		c = 0;
		do
		begin
			@(negedge pclk);
			c++;
		end
		while ((which ? bit_rate_tick : timer_tick) !== 1'b1 && c < 20000);
		if (c >= 20000)
		begin
			num_errors++;
			print_verdict();
		end
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		cmp({31'h0, port_reset}, 32'h1);
		// Reset values, then the error response of an unmapped word
		apb(1'b0, `SBRG_OFS_RX_CTL, 32'h0, rd, er);
		cmp(rd, 32'h00000000);
		cmp({31'h0, er}, 32'h0);
		apb(1'b0, `SBRG_OFS_DIVISOR, 32'h0, rd, er);
		cmp(rd, 32'h00000000);
		apb(1'b0, `SBRG_OFS_TX_CTL, 32'h0, rd, er);
		cmp(rd, 32'h00000002);
		apb(1'b1, 12'h010, 32'hFF, rd, er);
		cmp({31'h0, er}, 32'h1);
		apb(1'b0, 12'h010, 32'h0, rd, er);
		cmp({er, rd[30:0]}, 32'h80000000);
		apb(1'b1, `SBRG_OFS_TX_CTL, 32'hFF, rd, er);
		apb(1'b0, `SBRG_OFS_TX_CTL, 32'h0, rd, er);
		cmp(rd, 32'h000000F7);
		// Stalled clock enable must hold pready low
		@(posedge pclk);
		clk_en <= 1'b0;
		@(negedge pclk);
		cmp({31'h0, pready}, 32'h0);
		@(posedge pclk);
		clk_en <= 1'b1;
		apb(1'b1, `SBRG_OFS_RX_CTL, 32'h80, rd, er);
		@(negedge pclk);
		cmp({31'h0, port_reset}, 32'h0);
		for (int m = 0; m < 4; m++)
		begin
			apb(1'b1, `SBRG_OFS_TX_CTL, {24'h0, mode_tx[m]}, rd, er);
			apb(1'b1, `SBRG_OFS_DIVISOR, {24'h0, mode_n[m]}, rd, er);
			apb(1'b0, `SBRG_OFS_DIVISOR, 32'h0, rd, er);
			cmp(rd, {24'h0, mode_n[m]});
			wait_tick(1'b1, per);
			wait_tick(1'b1, per);
			cmp(per, mode_f[m] * (mode_n[m] + 1));
			wait_tick(1'b0, per);
			wait_tick(1'b0, per);
			cmp(per, mode_n[m] + 1);
		end
		// A large count is abandoned at once: first tick one cycle after the write edge
		apb(1'b1, `SBRG_OFS_DIVISOR, 32'hFA, rd, er);
		repeat (10) @(posedge pclk);
		apb(1'b1, `SBRG_OFS_DIVISOR, 32'h02, rd, er);
		wait_tick(1'b0, per);
		cmp(per, 2);
		// Disabled port: held in reset, no ticks at all
		apb(1'b1, `SBRG_OFS_RX_CTL, 32'h00, rd, er);
		// A tick launched at the disabling edge was decided while still enabled
		@(posedge pclk);
		per = 0;
		repeat (300)
		begin
			@(negedge pclk);
			if (timer_tick !== 1'b0 || bit_rate_tick !== 1'b0)
				per++;
		end
		cmp(per, 0);
		cmp({31'h0, port_reset}, 32'h1);
		// Status word shows both counters held at zero
		apb(1'b0, `SBRG_OFS_STATUS, 32'h0, rd, er);
		cmp(rd, 32'h00000000);
		print_verdict();
	end

endmodule
